// File: rtl/cfr_pkg.sv
// Shared constants of the current fault response and configuration block
package cfr_pkg;
	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_STATUS_IOUT = 8'h7b;
	localparam logic [7:0] CMD_UC_FAULT_ACTION = 8'he6;
	localparam logic [7:0] CMD_AVG_OC_LIMIT = 8'he7;
	localparam logic [7:0] CMD_AVG_UC_LIMIT = 8'he8;
	localparam logic [7:0] CMD_MISC_OPTIONS = 8'he9;
	localparam logic [7:0] CMD_PHASE_CONTROL = 8'hf0;
	localparam logic [7:0] CMD_CAPTURE_CONTROL = 8'hf3;

	// ------------------------------------------------------------
	// Reset values and write mask
	// ------------------------------------------------------------
	localparam logic [7:0] UC_FAULT_ACTION_RST = 8'h80;
	localparam logic [15:0] AVG_OC_LIMIT_RST = 16'hd249;
	localparam logic [15:0] AVG_UC_LIMIT_RST = 16'hd5b7;
	localparam logic [15:0] MISC_OPTIONS_RST = 16'h2000;
	localparam logic [7:0] PHASE_CONTROL_RST = 8'h00;
	localparam logic [15:0] MISC_OPTIONS_MASK = 16'he046;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ACT_MODE_HI = 7;
	localparam int ACT_MODE_LO = 6;
	localparam int ACT_RETRY_HI = 5;
	localparam int ACT_RETRY_LO = 3;
	localparam int ACT_TIME_HI = 2;
	localparam int ACT_TIME_LO = 0;
	localparam int MISC_PHASE_SEL_BIT = 13;
	localparam int MISC_DIODE_EMUL_BIT = 6;
	localparam int MISC_MIN_GATE_BIT = 2;
	localparam int MISC_CAPTURE_BIT = 1;
	localparam int STAT_OC_BIT = 7;
	localparam int STAT_UC_BIT = 4;
	localparam int L11_EXP_LO = 11;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_IGNORE = 2'h0;
	localparam logic [1:0] MODE_DELAY_OFF = 2'h1;
	localparam logic [1:0] MODE_OFF_RETRY = 2'h2;
	localparam logic [1:0] MODE_HOLD_OFF = 2'h3;
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_FOREVER = 3'h7;
	localparam logic [7:0] PHASE_ADD = 8'h01;
	localparam logic [7:0] CAPTURE_LOAD = 8'h01;
	localparam logic [7:0] CAPTURE_STORE = 8'h02;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CORE_CLK_MHZ = 100;
	localparam int UC_TIME_UNIT_US = 10;
	localparam int UC_TIME_UNIT_CYC = UC_TIME_UNIT_US * CORE_CLK_MHZ;
	localparam int MIN_GATE_PCT = 10;
	localparam int PCT_FULL = 100;

	typedef enum logic [5:0] {
		ST_RUN = 6'b000001,
		ST_DELAY = 6'b000010,
		ST_OFF = 6'b000100,
		ST_RETRY_WAIT = 6'b001000,
		ST_LATCHED = 6'b010000,
		ST_HOLD = 6'b100000
	} cfr_state_t;
endpackage

// File: rtl/cfr_sense_avg.sv
// Per-cycle current sample accumulator running on the sense clock
`timescale 1ns/10ps
module cfr_sense_avg #(
	parameter int SAMPLE_W = 16,
	parameter int CNT_W = 8,
	parameter int SUM_W = 24
) (
	input wire logic i_sense_clk,
	input wire logic i_rst_n,
	input wire logic i_upslope,
	input wire logic i_valid,
	input wire logic signed [SAMPLE_W-1:0] i_sample,
	input wire logic i_sw_on,
	input wire logic i_blank,
	input wire logic i_cycle_end,
	output logic signed [SUM_W-1:0] o_sum,
	output logic [CNT_W-1:0] o_count,
	output logic o_toggle
);
	import cfr_pkg::*;

	logic up_s1_q;
	logic up_s2_q;
	logic signed [SUM_W-1:0] acc_q;
	logic [CNT_W-1:0] cnt_q;
	logic take;

	always_ff @(posedge i_sense_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			up_s1_q <= 1'b0;
			up_s2_q <= 1'b0;
		end else begin
			up_s1_q <= i_upslope;
			up_s2_q <= up_s1_q;
		end
	end

	// Window is the on-time for up-slope, off-time for down-slope, minus blanking
	assign take = i_valid && !i_blank && (up_s2_q ? i_sw_on : !i_sw_on) && (cnt_q != '1); // see [RQ12] see [RQ13]

	always_ff @(posedge i_sense_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_q <= '0;
			cnt_q <= '0;
		end else if (i_cycle_end) begin
			acc_q <= '0;
			cnt_q <= '0;
		end else if (take) begin
			acc_q <= acc_q + SUM_W'(i_sample);
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// Result words stay still a whole switching cycle, long enough for the core side to capture
	always_ff @(posedge i_sense_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sum <= '0;
			o_count <= '0;
			o_toggle <= 1'b0;
		end else if (i_cycle_end) begin
			o_sum <= acc_q;
			o_count <= cnt_q;
			o_toggle <= !o_toggle; // see [RQ23]
		end
	end
endmodule

// File: rtl/cfr_top.sv
// Undercurrent fault response, averaged current limits and option word
`timescale 1ns/10ps
// How it works
// [RQ1] Undercurrent action register; fault sets status bit
// [RQ2] Mode 00 keeps running, still flags fault
// [RQ3] Mode 01 delays, disables, then retries
// [RQ4] Mode 10 disables at once, then retries
// [RQ5] Mode 11 off while fault, auto recover
// [RQ6] Status bits sticky, cleared by fault-clear command
// [RQ7] Retry 000: stay off until restarted
// [RQ8] Retry 1..6: that many spaced restarts
// [RQ9] Retry 111: restart forever until shutdown
// [RQ10] Time field sets delay and retry spacing
// [RQ11] Averaged overcurrent limit, linear format, compared
// [RQ12] Down-slope: average off-time samples minus blanking
// [RQ13] Up-slope: average on-time samples minus blanking
// [RQ14] Averaged overcurrent uses overcurrent bit, response
// [RQ15] Averaged undercurrent limit, same averaging
// [RQ16] Averaged undercurrent uses undercurrent bit, response
// [RQ17] Bit 13 clear: phase follows enable pin
// [RQ18] Bit 13 set: phase follows phase command
// [RQ19] Bit 6 enables light-load diode emulation
// [RQ20] Bit 2: low-side pulse at least ten percent
// [RQ21] Phase command 01h adds, 00h drops
// [RQ22] Capture enabled blocks nonvolatile load request
// [RQ23] Averages compared once per switching cycle
// [RQ24] Host zeroes reserved bits, clears faults after
module cfr_top #(
	parameter int SAMPLE_W = 16,
	parameter int CNT_W = 8,
	parameter int SUM_W = 24,
	parameter int FRAC_W = 4,
	parameter int PERIOD_W = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_cmd_wr,
	input wire logic i_cmd_rd,
	input wire logic [7:0] i_cmd_code,
	input wire logic [15:0] i_cmd_wdata,
	output logic [15:0] o_rdata,
	output logic o_rd_valid,
	output logic o_cmd_unsupported,
	input wire logic i_sense_clk,
	input wire logic i_upslope_sense,
	input wire logic i_sense_valid,
	input wire logic signed [SAMPLE_W-1:0] i_sense_sample,
	input wire logic i_sw_on,
	input wire logic i_blank,
	input wire logic i_cycle_end,
	input wire logic i_uc_fault,
	input wire logic i_oc_peak_fault,
	input wire logic i_restart,
	input wire logic i_shutdown,
	input wire logic i_phase_enable_pin,
	input wire logic i_light_load,
	input wire logic [PERIOD_W-1:0] i_sw_period,
	output logic o_output_enable,
	output logic o_avg_oc_event,
	output logic o_phase_active,
	output logic o_diode_emul_en,
	output logic [PERIOD_W-1:0] o_min_low_side_gate,
	output logic o_nvm_load_req,
	output logic o_nvm_store_req,
	output cfr_pkg::cfr_state_t o_uc_state
);
	import cfr_pkg::*;

	localparam int PROD_W = SUM_W + CNT_W + 2;
	localparam int DLY_W = 16;

	// Linear format: 5-bit signed exponent over 11-bit signed mantissa, to fixed point
	function automatic logic signed [SUM_W-1:0] l11_to_fix(input logic [15:0] w);
		logic signed [5:0] e;
		logic signed [SUM_W-1:0] y;
		e = 6'(signed'(w[15:L11_EXP_LO])) + 6'(FRAC_W);
		y = SUM_W'(signed'(w[L11_EXP_LO-1:0]));
		if (e >= 0) begin
			l11_to_fix = y <<< e;
		end else begin
			l11_to_fix = y >>> (-e);
		end
	endfunction

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] uc_action_q;
	logic [15:0] avg_oc_limit_q;
	logic [15:0] avg_uc_limit_q;
	logic [15:0] misc_q;
	logic [7:0] phase_ctrl_q;
	logic [7:0] status_q;
	logic wr_en;
	logic clr_faults;
	logic uc_evt;
	logic oc_evt;

	assign wr_en = i_ce && i_cmd_wr;
	assign clr_faults = wr_en && (i_cmd_code == CMD_CLEAR_FAULTS);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			uc_action_q <= UC_FAULT_ACTION_RST;
			avg_oc_limit_q <= AVG_OC_LIMIT_RST;
			avg_uc_limit_q <= AVG_UC_LIMIT_RST;
			misc_q <= MISC_OPTIONS_RST;
			phase_ctrl_q <= PHASE_CONTROL_RST;
		end else if (wr_en) begin
			if (i_cmd_code == CMD_UC_FAULT_ACTION) begin
				uc_action_q <= i_cmd_wdata[7:0]; // see [RQ1]
			end else if (i_cmd_code == CMD_AVG_OC_LIMIT) begin
				avg_oc_limit_q <= i_cmd_wdata; // see [RQ11]
			end else if (i_cmd_code == CMD_AVG_UC_LIMIT) begin
				avg_uc_limit_q <= i_cmd_wdata; // see [RQ15]
			end else if (i_cmd_code == CMD_MISC_OPTIONS) begin
				// Reserved bits are dropped so they always read back as zero
				misc_q <= i_cmd_wdata & MISC_OPTIONS_MASK; // see [RQ24]
			end else if (i_cmd_code == CMD_PHASE_CONTROL) begin
				phase_ctrl_q <= i_cmd_wdata[7:0];
			end
		end
	end

	// Sticky status: a fault in the clearing cycle survives the clear
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_q <= '0;
		end else if (i_ce) begin
			status_q[STAT_UC_BIT] <= uc_evt || (status_q[STAT_UC_BIT] && !clr_faults); // see [RQ6] see [RQ16]
			status_q[STAT_OC_BIT] <= oc_evt || (status_q[STAT_OC_BIT] && !clr_faults); // see [RQ14]
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= '0;
			o_rd_valid <= 1'b0;
			o_cmd_unsupported <= 1'b0;
		end else if (i_ce) begin
			o_rd_valid <= i_cmd_rd;
			o_cmd_unsupported <= 1'b0;
			if (i_cmd_rd) begin
				if (i_cmd_code == CMD_UC_FAULT_ACTION) begin
					o_rdata <= {8'h00, uc_action_q};
				end else if (i_cmd_code == CMD_AVG_OC_LIMIT) begin
					o_rdata <= avg_oc_limit_q;
				end else if (i_cmd_code == CMD_AVG_UC_LIMIT) begin
					o_rdata <= avg_uc_limit_q;
				end else if (i_cmd_code == CMD_MISC_OPTIONS) begin
					o_rdata <= misc_q;
				end else if (i_cmd_code == CMD_PHASE_CONTROL) begin
					o_rdata <= {8'h00, phase_ctrl_q};
				end else if (i_cmd_code == CMD_STATUS_IOUT) begin
					o_rdata <= {8'h00, status_q};
				end else begin
					o_rdata <= '0;
					o_cmd_unsupported <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Sense-domain averaging and crossing
	// ------------------------------------------------------------
	logic signed [SUM_W-1:0] sense_sum;
	logic [CNT_W-1:0] sense_count;
	logic sense_toggle;
	logic tog_s1_q;
	logic tog_s2_q;
	logic tog_s3_q;
	logic new_avg;
	logic cmp_pend_q;
	logic cmp_done_q;
	logic signed [SUM_W-1:0] cap_sum_q;
	logic [CNT_W-1:0] cap_count_q;
	logic avg_oc_viol_q;
	logic avg_uc_viol_q;
	logic avg_oc_pulse;
	logic avg_uc_pulse;
	logic signed [PROD_W-1:0] oc_bound;
	logic signed [PROD_W-1:0] uc_bound;
	logic signed [PROD_W-1:0] sum_ext;

	cfr_sense_avg #(
		.SAMPLE_W(SAMPLE_W),
		.CNT_W(CNT_W),
		.SUM_W(SUM_W)
	) u_sense_avg (
		.i_sense_clk(i_sense_clk),
		.i_rst_n(i_rst_n),
		.i_upslope(i_upslope_sense),
		.i_valid(i_sense_valid),
		.i_sample(i_sense_sample),
		.i_sw_on(i_sw_on),
		.i_blank(i_blank),
		.i_cycle_end(i_cycle_end),
		.o_sum(sense_sum),
		.o_count(sense_count),
		.o_toggle(sense_toggle)
	);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
			tog_s3_q <= 1'b0;
		end else if (i_ce) begin
			tog_s1_q <= sense_toggle;
			tog_s2_q <= tog_s1_q;
			tog_s3_q <= tog_s2_q;
		end
	end

	assign new_avg = tog_s2_q ^ tog_s3_q;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cap_sum_q <= '0;
			cap_count_q <= '0;
			cmp_pend_q <= 1'b0;
			cmp_done_q <= 1'b0;
		end else if (i_ce) begin
			cmp_pend_q <= new_avg;
			cmp_done_q <= cmp_pend_q;
			if (new_avg) begin
				cap_sum_q <= sense_sum;
				cap_count_q <= sense_count;
			end
		end
	end

	// Mean vs limit without a divider: compare sum against limit times count
	assign sum_ext = PROD_W'(cap_sum_q);
	assign oc_bound = PROD_W'(l11_to_fix(avg_oc_limit_q)) * PROD_W'(signed'({1'b0, cap_count_q}));
	assign uc_bound = PROD_W'(l11_to_fix(avg_uc_limit_q)) * PROD_W'(signed'({1'b0, cap_count_q}));

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			avg_oc_viol_q <= 1'b0;
			avg_uc_viol_q <= 1'b0;
		end else if (i_ce && cmp_pend_q) begin
			// A cycle with no valid samples carries no verdict
			avg_oc_viol_q <= (cap_count_q != '0) && (sum_ext > oc_bound); // see [RQ11] see [RQ23]
			avg_uc_viol_q <= (cap_count_q != '0) && (sum_ext < uc_bound); // see [RQ15] see [RQ23]
		end
	end

	assign avg_oc_pulse = cmp_done_q && avg_oc_viol_q;
	assign avg_uc_pulse = cmp_done_q && avg_uc_viol_q;
	assign oc_evt = i_ce && (avg_oc_pulse || i_oc_peak_fault); // see [RQ14]
	assign o_avg_oc_event = i_ce && avg_oc_pulse; // see [RQ14]

	// ------------------------------------------------------------
	// Undercurrent response state machine
	// ------------------------------------------------------------
	cfr_state_t st_q;
	logic [DLY_W-1:0] tmr_q;
	logic [2:0] used_q;
	logic [1:0] mode;
	logic [2:0] retry;
	logic [DLY_W-1:0] span;
	logic uc_cond;

	assign mode = uc_action_q[ACT_MODE_HI:ACT_MODE_LO];
	assign retry = uc_action_q[ACT_RETRY_HI:ACT_RETRY_LO];
	// Field value zero still costs one cycle
	assign span = (uc_action_q[ACT_TIME_HI:ACT_TIME_LO] == 3'h0) ? DLY_W'(1) :
		DLY_W'(uc_action_q[ACT_TIME_HI:ACT_TIME_LO]) * DLY_W'(UC_TIME_UNIT_CYC); // see [RQ10]
	assign uc_cond = i_uc_fault || avg_uc_viol_q;
	assign uc_evt = i_ce && (i_uc_fault || avg_uc_pulse); // see [RQ1] see [RQ16] see [RQ2]

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= ST_RUN;
			tmr_q <= '0;
			used_q <= '0;
		end else if (i_ce) begin
			if (i_shutdown) begin
				st_q <= ST_LATCHED; // see [RQ9]
			end else if (i_restart && st_q != ST_RUN) begin
				st_q <= ST_RUN; // see [RQ7]
				used_q <= '0;
			end else begin
				case (st_q)
					ST_RUN: begin
						if (uc_evt) begin
							if (mode == MODE_DELAY_OFF) begin
								st_q <= ST_DELAY; // see [RQ3]
								tmr_q <= span;
							end else if (mode == MODE_OFF_RETRY) begin
								st_q <= ST_OFF; // see [RQ4]
							end else if (mode == MODE_HOLD_OFF) begin
								st_q <= ST_HOLD; // see [RQ5]
							end
						end
					end
					ST_DELAY: begin
						if (tmr_q <= DLY_W'(1)) begin
							st_q <= ST_OFF; // see [RQ3] see [RQ10]
						end else begin
							tmr_q <= tmr_q - 1'b1;
						end
					end
					ST_OFF: begin
						if (retry == RETRY_NONE || (retry != RETRY_FOREVER && used_q >= retry)) begin
							st_q <= ST_LATCHED; // see [RQ7] see [RQ8]
						end else begin
							st_q <= ST_RETRY_WAIT;
							tmr_q <= span; // see [RQ8] see [RQ10]
						end
					end
					ST_RETRY_WAIT: begin
						if (tmr_q <= DLY_W'(1)) begin
							st_q <= ST_RUN;
							// Forever mode never exhausts its count
							if (retry != RETRY_FOREVER) begin
								used_q <= used_q + 1'b1; // see [RQ8]
							end
						end else begin
							tmr_q <= tmr_q - 1'b1;
						end
					end
					ST_LATCHED: begin
						st_q <= ST_LATCHED; // see [RQ7]
					end
					ST_HOLD: begin
						if (!uc_cond) begin
							st_q <= ST_RUN; // see [RQ5]
						end
					end
					default: begin
						st_q <= ST_LATCHED;
					end
				endcase
			end
		end
	end

	assign o_output_enable = (st_q == ST_RUN) || (st_q == ST_DELAY); // see [RQ2] see [RQ3]
	assign o_uc_state = st_q;

	// ------------------------------------------------------------
	// Phase, diode emulation and capture control
	// ------------------------------------------------------------
	logic ph_s1_q;
	logic ph_s2_q;
	logic [PERIOD_W+3:0] period_tenth;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ph_s1_q <= 1'b0;
			ph_s2_q <= 1'b0;
		end else if (i_ce) begin
			ph_s1_q <= i_phase_enable_pin;
			ph_s2_q <= ph_s1_q;
		end
	end

	// Rounded up so the floor never drops under the stated fraction
	assign period_tenth = ((PERIOD_W+4)'(i_sw_period) * (PERIOD_W+4)'(MIN_GATE_PCT) +
		(PERIOD_W+4)'(PCT_FULL - 1)) / (PERIOD_W+4)'(PCT_FULL);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_phase_active <= 1'b0;
			o_diode_emul_en <= 1'b0;
			o_min_low_side_gate <= '0;
		end else if (i_ce) begin
			if (misc_q[MISC_PHASE_SEL_BIT]) begin
				o_phase_active <= (phase_ctrl_q == PHASE_ADD); // see [RQ18] see [RQ21]
			end else begin
				o_phase_active <= ph_s2_q; // see [RQ17]
			end
			o_diode_emul_en <= misc_q[MISC_DIODE_EMUL_BIT] && i_light_load; // see [RQ19]
			if (misc_q[MISC_DIODE_EMUL_BIT] && misc_q[MISC_MIN_GATE_BIT] && i_light_load) begin
				o_min_low_side_gate <= period_tenth[PERIOD_W-1:0]; // see [RQ20]
			end else begin
				o_min_low_side_gate <= '0;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_nvm_load_req <= 1'b0;
			o_nvm_store_req <= 1'b0;
		end else if (i_ce) begin
			o_nvm_load_req <= wr_en && (i_cmd_code == CMD_CAPTURE_CONTROL) &&
				(i_cmd_wdata[7:0] == CAPTURE_LOAD) && !misc_q[MISC_CAPTURE_BIT]; // see [RQ22]
			o_nvm_store_req <= wr_en && (i_cmd_code == CMD_CAPTURE_CONTROL) &&
				(i_cmd_wdata[7:0] == CAPTURE_STORE);
		end
	end
endmodule

// File: tb/cfr_props.sv
// Port-level assertions for the current fault response block
`timescale 1ns/10ps
module cfr_props
	import cfr_pkg::*;
#(
	parameter int PERIOD_W = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_cmd_wr,
	input wire logic i_cmd_rd,
	input wire logic [7:0] i_cmd_code,
	input wire logic [15:0] i_cmd_wdata,
	input wire logic o_rd_valid,
	input wire logic o_cmd_unsupported,
	input wire logic i_uc_fault,
	input wire logic i_restart,
	input wire logic i_shutdown,
	input wire logic i_light_load,
	input wire logic o_output_enable,
	input wire logic o_avg_oc_event,
	input wire logic o_diode_emul_en,
	input wire logic [PERIOD_W-1:0] o_min_low_side_gate,
	input wire logic o_nvm_load_req,
	input wire cfr_state_t o_uc_state
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	AST_RD_VALID: assert property (o_rd_valid == $past(i_ce && i_cmd_rd))
		else $error("read answer not exactly one cycle after request");
	AST_UNSUP_WITH_VALID: assert property (o_cmd_unsupported |-> o_rd_valid)
		else $error("unsupported flag outside a read answer");
	AST_OUTEN_STATE: assert property (o_output_enable == (o_uc_state inside {ST_RUN, ST_DELAY}))
		else $error("output enable does not match response state");
	AST_SHUTDOWN_LATCH: assert property (i_ce && i_shutdown |=> o_uc_state == ST_LATCHED)
		else $error("shutdown did not latch the output off");
	AST_LATCH_HOLDS: assert property (i_ce && !i_restart && o_uc_state == ST_LATCHED |=> o_uc_state == ST_LATCHED)
		else $error("latched off state left without restart");
	AST_OFF_NEXT: assert property (i_ce && !i_restart && !i_shutdown && o_uc_state == ST_OFF
		|=> o_uc_state inside {ST_LATCHED, ST_RETRY_WAIT})
		else $error("off state not followed by retry wait or latch");
	AST_HOLD_WHILE_FAULT: assert property (i_ce && i_uc_fault && !i_restart && !i_shutdown
		&& o_uc_state == ST_HOLD |=> o_uc_state == ST_HOLD)
		else $error("hold state left while fault present");
	AST_DIODE_LOAD: assert property (o_diode_emul_en |-> $past(i_light_load))
		else $error("diode emulation without light load");
	AST_MIN_GATE: assert property (o_min_low_side_gate != '0 |-> o_diode_emul_en)
		else $error("minimum gate pulse outside diode emulation");
	AST_LOAD_CAUSE: assert property (o_nvm_load_req
		|-> $past(i_cmd_wr && i_cmd_code == CMD_CAPTURE_CONTROL && i_cmd_wdata[7:0] == CAPTURE_LOAD))
		else $error("load request without a load command");

	COV_HOLD: cover property (o_uc_state == ST_HOLD);
	COV_DELAY: cover property (o_uc_state == ST_DELAY);
	COV_LATCH: cover property (o_uc_state == ST_LATCHED);
	COV_AVG_OC: cover property (o_avg_oc_event);
endmodule

// File: tb/cfr_sense_model.sv
// Behavioural switching-cycle source driving the sense link
`timescale 1ns/10ps
module cfr_sense_model (
	input wire logic i_sense_clk,
	input wire logic i_go,
	input wire logic i_up,
	input wire logic signed [15:0] i_val,
	output logic o_valid,
	output logic signed [15:0] o_sample,
	output logic o_sw_on,
	output logic o_blank,
	output logic o_cycle_end
);
	logic last_go = 1'b0;
	int k;
	initial begin
		o_valid = 1'b0;
		o_sample = 16'sh0000;
		o_sw_on = 1'b0;
		o_blank = 1'b0;
		o_cycle_end = 1'b0;
		forever begin
			@(posedge i_sense_clk);
			#1;
			// Idle line toggles so a stale sample can never look valid
			o_sample = ~o_sample;
			if (i_go !== last_go) begin
				last_go = i_go;
				for (k = 0; k < 12; k++) begin
					o_valid = (k < 10);
					o_cycle_end = (k == 10);
					o_blank = (k < 2);
					o_sw_on = (k < 6) ? i_up : !i_up;
					// Blanked and out-of-window samples carry the opposite sign to expose leaks
					o_sample = (k >= 10) ? ~o_sample : ((k >= 2 && k < 6) ? i_val : -i_val);
					@(posedge i_sense_clk);
					#1;
				end
			end
		end
	end
endmodule

// File: tb/cfr_top_test.sv
// Command-level test of the current fault response block
`timescale 1ns/10ps
module cfr_top_test;
	import cfr_pkg::*;
	logic i_core_clk = 1'b0, i_sense_clk = 1'b0, i_rst_n = 1'b0, i_ce = 1'b1, i_cmd_wr = 1'b0, i_cmd_rd = 1'b0;
	logic i_uc_fault = 1'b0, i_oc_peak_fault = 1'b0, i_restart = 1'b0, i_shutdown = 1'b0, go = 1'b0, up = 1'b0;
	logic i_phase_enable_pin = 1'b0, i_light_load = 1'b0, uns, oc_seen = 1'b0, ld_seen = 1'b0, st_seen = 1'b0;
	logic [7:0] i_cmd_code = 8'h00;
	logic [15:0] i_cmd_wdata = 16'h0000, i_sw_period = 16'h005f, rv, o_rdata, o_min_low_side_gate;
	logic signed [15:0] val = 16'sh0000, i_sense_sample;
	logic o_rd_valid, o_cmd_unsupported, o_output_enable, o_avg_oc_event, o_phase_active, o_diode_emul_en;
	logic o_nvm_load_req, o_nvm_store_req, i_sense_valid, i_sw_on, i_blank, i_cycle_end, i_upslope_sense;
	cfr_state_t o_uc_state;
	int fail_count = 0, checked = 0, n;
	logic [7:0] codes [7] = '{8'he6, 8'he7, 8'he8, 8'he9, 8'hf0, 8'h7b, 8'h55};
	logic [15:0] exps [7] = '{16'h0080, 16'hd249, 16'hd5b7, 16'h2000, 16'h0000, 16'h0000, 16'h0000};

	initial forever #5 i_core_clk = ~i_core_clk;
	initial begin
		#3;
		forever #16 i_sense_clk = ~i_sense_clk;
	end
	assign i_upslope_sense = up;

	cfr_top DUT (.i_core_clk, .i_rst_n, .i_ce, .i_cmd_wr, .i_cmd_rd, .i_cmd_code, .i_cmd_wdata, .o_rdata,
		.o_rd_valid, .o_cmd_unsupported, .i_sense_clk, .i_upslope_sense, .i_sense_valid, .i_sense_sample,
		.i_sw_on, .i_blank, .i_cycle_end, .i_uc_fault, .i_oc_peak_fault, .i_restart, .i_shutdown,
		.i_phase_enable_pin, .i_light_load, .i_sw_period, .o_output_enable, .o_avg_oc_event, .o_phase_active,
		.o_diode_emul_en, .o_min_low_side_gate, .o_nvm_load_req, .o_nvm_store_req, .o_uc_state);
	cfr_sense_model u_sense (.i_sense_clk, .i_go(go), .i_up(up), .i_val(val), .o_valid(i_sense_valid),
		.o_sample(i_sense_sample), .o_sw_on(i_sw_on), .o_blank(i_blank), .o_cycle_end(i_cycle_end));

	always @(posedge i_core_clk) begin
		if (o_avg_oc_event === 1'b1)
			oc_seen = 1'b1;
		if (o_nvm_load_req === 1'b1)
			ld_seen = 1'b1;
		if (o_nvm_store_req === 1'b1)
			st_seen = 1'b1;
	end

	task automatic cyc(input int c);
		repeat (c) @(posedge i_core_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		i_cmd_wr = 1'b1;
		i_cmd_code = c;
		i_cmd_wdata = d;
		cyc(1);
		i_cmd_wr = 1'b0;
		cyc(1);
	endtask
	task automatic rd(input logic [7:0] c);
		int k;
		i_cmd_rd = 1'b1;
		i_cmd_code = c;
		cyc(1);
		i_cmd_rd = 1'b0;
		for (k = 0; k < 4 && o_rd_valid !== 1'b1; k++)
			cyc(1);
		if (k == 4) begin
			chk(16'h0000, 16'h0001);
			tally_and_finish;
		end
		rv = o_rdata;
		uns = o_cmd_unsupported;
		cyc(1);
	endtask
	task automatic ws(input cfr_state_t st, input int bound);
		for (n = 0; n < bound && o_uc_state !== st; n++)
			cyc(1);
		chk(16'(o_uc_state), 16'(st));
		if (o_uc_state !== st)
			tally_and_finish;
	endtask
	task automatic restart_clean;
		i_uc_fault = 1'b0;
		i_shutdown = 1'b0;
		i_restart = 1'b1;
		cyc(1);
		i_restart = 1'b0;
		cyc(1);
	endtask
	task automatic sc(input logic u, input logic signed [15:0] v);
		up = u;
		val = v;
		cyc(10);
		oc_seen = 1'b0;
		go = ~go;
		cyc(60);
	endtask

	initial begin
		cyc(6);
		i_rst_n = 1'b1;
		foreach (codes[i]) begin
			rd(codes[i]);
			chk(rv, exps[i]);
			chk(16'(uns), 16'(codes[i] == 8'h55));
		end
		wr(CMD_MISC_OPTIONS, 16'hffff);
		rd(CMD_MISC_OPTIONS);
		chk(rv, 16'he046);
		wr(CMD_STATUS_IOUT, 16'hffff);
		rd(CMD_STATUS_IOUT);
		chk(rv, 16'h0000);
		i_ce = 1'b0;
		wr(CMD_PHASE_CONTROL, 16'h0001);
		i_ce = 1'b1;
		rd(CMD_PHASE_CONTROL);
		chk(rv, 16'h0000);
		wr(CMD_MISC_OPTIONS, 16'h2000);
		// Ignore mode keeps running but still flags the fault
		wr(CMD_UC_FAULT_ACTION, 16'h0000);
		i_uc_fault = 1'b1;
		cyc(5);
		chk(16'(o_uc_state), 16'(ST_RUN));
		i_uc_fault = 1'b0;
		i_oc_peak_fault = 1'b1;
		cyc(2);
		i_oc_peak_fault = 1'b0;
		rd(CMD_STATUS_IOUT);
		chk(rv, 16'h0090);
		wr(CMD_CLEAR_FAULTS, 16'h0000);
		rd(CMD_STATUS_IOUT);
		chk(rv, 16'h0000);
		// Disable, one retry after one time step, then latch
		wr(CMD_UC_FAULT_ACTION, 16'h0089);
		i_uc_fault = 1'b1;
		ws(ST_OFF, 3);
		ws(ST_RETRY_WAIT, 3);
		ws(ST_RUN, 1100);
		chk(16'(n >= 990 && n <= 1010), 16'h0001);
		ws(ST_LATCHED, 6);
		cyc(20);
		chk(16'(o_uc_state), 16'(ST_LATCHED));
		restart_clean;
		chk(16'(o_uc_state), 16'(ST_RUN));
		// Delay two steps with output on, no retry
		wr(CMD_UC_FAULT_ACTION, 16'h0042);
		i_uc_fault = 1'b1;
		ws(ST_DELAY, 3);
		chk(16'(o_output_enable), 16'h0001);
		ws(ST_OFF, 2100);
		chk(16'(n >= 1990 && n <= 2010), 16'h0001);
		ws(ST_LATCHED, 3);
		restart_clean;
		// Hold off while fault present, recover on its own
		wr(CMD_UC_FAULT_ACTION, 16'h00c0);
		i_uc_fault = 1'b1;
		ws(ST_HOLD, 3);
		cyc(10);
		chk(16'(o_output_enable), 16'h0000);
		i_uc_fault = 1'b0;
		ws(ST_RUN, 5);
		// Endless retries stop only on shutdown
		wr(CMD_UC_FAULT_ACTION, 16'h00b8);
		i_uc_fault = 1'b1;
		ws(ST_RETRY_WAIT, 4);
		ws(ST_RUN, 8);
		ws(ST_RETRY_WAIT, 8);
		i_shutdown = 1'b1;
		cyc(2);
		chk(16'(o_uc_state), 16'(ST_LATCHED));
		restart_clean;
		// Averaged limits, both slopes; blanked and off-window samples must not count
		wr(CMD_UC_FAULT_ACTION, 16'h0000);
		wr(CMD_CLEAR_FAULTS, 16'h0000);
		for (int u = 0; u < 2; u++) begin
			sc(u[0], 16'sh00a0);
			chk(16'(oc_seen), 16'h0001);
			rd(CMD_STATUS_IOUT);
			chk(rv, 16'h0080);
			sc(u[0], 16'sh0000);
			wr(CMD_CLEAR_FAULTS, 16'h0000);
		end
		wr(CMD_AVG_OC_LIMIT, 16'h0014);
		sc(1'b0, 16'sh00a0);
		chk(16'(oc_seen), 16'h0000);
		wr(CMD_AVG_OC_LIMIT, 16'hd249);
		sc(1'b0, 16'shff60);
		chk(16'(oc_seen), 16'h0000);
		rd(CMD_STATUS_IOUT);
		chk(rv, 16'h0010);
		sc(1'b0, 16'sh0000);
		wr(CMD_CLEAR_FAULTS, 16'h0000);
		// Phase source, diode emulation and capture options
		i_phase_enable_pin = 1'b1;
		wr(CMD_PHASE_CONTROL, 16'h0001);
		cyc(3);
		chk(16'(o_phase_active), 16'h0001);
		wr(CMD_PHASE_CONTROL, 16'h0000);
		cyc(3);
		chk(16'(o_phase_active), 16'h0000);
		wr(CMD_MISC_OPTIONS, 16'h0000);
		cyc(4);
		chk(16'(o_phase_active), 16'h0001);
		i_phase_enable_pin = 1'b0;
		cyc(4);
		chk(16'(o_phase_active), 16'h0000);
		i_light_load = 1'b1;
		wr(CMD_MISC_OPTIONS, 16'h0044);
		cyc(3);
		chk(16'(o_diode_emul_en), 16'h0001);
		chk(o_min_low_side_gate, 16'h000a);
		wr(CMD_MISC_OPTIONS, 16'h0040);
		cyc(3);
		chk(o_min_low_side_gate, 16'h0000);
		wr(CMD_MISC_OPTIONS, 16'h0002);
		wr(CMD_CAPTURE_CONTROL, 16'h0001);
		cyc(3);
		chk(16'(ld_seen), 16'h0000);
		wr(CMD_MISC_OPTIONS, 16'h0000);
		cyc(3);
		chk(16'(o_diode_emul_en), 16'h0000);
		wr(CMD_CAPTURE_CONTROL, 16'h0001);
		wr(CMD_CAPTURE_CONTROL, 16'h0002);
		cyc(3);
		chk(16'(ld_seen), 16'h0001);
		chk(16'(st_seen), 16'h0001);
		tally_and_finish;
	end
endmodule

bind cfr_top cfr_props #(.PERIOD_W(PERIOD_W)) u_props (.i_core_clk, .i_rst_n, .i_ce, .i_cmd_wr, .i_cmd_rd,
	.i_cmd_code, .i_cmd_wdata, .o_rd_valid, .o_cmd_unsupported, .i_uc_fault, .i_restart, .i_shutdown,
	.i_light_load, .o_output_enable, .o_avg_oc_event, .o_diode_emul_en, .o_min_low_side_gate,
	.o_nvm_load_req, .o_uc_state);
